// ==== logic/aopc_pkg.sv ====
// Purpose: Shared constants and types for the converter output and power control.
// Assumes: Control clock of 125 MHz; encode clock arrives as its own clock domain.
// Notes: Sample word is the core's offset-binary code; coding is applied on the way out.
package aopc_pkg;
   // Sample word
   localparam int SAMPLE_W = 11;
   localparam logic [10:0] MSB_FLIP = 11'h400;
   localparam int MSB_POS = 10;
   // Configuration pin levels, as resolved by the four-level detector
   localparam logic [1:0] MODE_GND = 2'h0;
   localparam logic [1:0] MODE_THIRD = 2'h1;
   localparam logic [1:0] MODE_TWO_THIRDS = 2'h2;
   localparam logic [1:0] MODE_SUPPLY = 2'h3;
   localparam int MODE_FMT_BIT = 1;
   // Control clock
   localparam int CLK_PERIOD_NS = 8;
   // Encode rate limits kept by the clock source
   localparam int MAX_RATE_MSPS = 105;
   localparam int MIN_RATE_MSPS = 1;
   // Encode clock counts as stopped once a gap reaches the slowest legal period
   localparam int STOP_NS = 1000 / MIN_RATE_MSPS;
   localparam int STOP_CYCLES = STOP_NS / CLK_PERIOD_NS;
   localparam int GAP_W = 8;
   localparam logic [7:0] STOP_CNT = 8'(STOP_CYCLES);
   localparam logic [7:0] GAP_MAX = 8'hFF;
   // Encode rise to detection in the control domain, in control cycles
   localparam logic [7:0] SYNC_LAT = 8'h02;
   // Stabilizer relock and nap recovery, in encode cycles
   localparam int LOCK_EDGES = 100;
   localparam int NAP_WAKE_EDGES = 100;
   localparam int EDGE_W = 7;
   // Sleep recovery, a least time rounded up to whole control cycles
   localparam int SLEEP_WAKE_MS = 2;
   localparam int SLEEP_WAKE_CYCLES = (SLEEP_WAKE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WAKE_W = 18;
   // Synchroniser widths toward each domain
   localparam int SYNC_C_W = 5;
   localparam int SYNC_E_W = 3;
   // Power states
   typedef enum logic [2:0] {
      PWR_RUN,
      PWR_NAP,
      PWR_SLEEP,
      PWR_NAP_WAKE,
      PWR_SLEEP_WAKE
   } aopc_pwr_t;
endpackage : aopc_pkg

// ==== logic/aopc_sync.sv ====
// Purpose: Two-flop level synchroniser.
// Assumes: Input is a level that stays put for several destination cycles.
// Notes: The first flop feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module aopc_sync (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic async_i,
   output logic sync_o
);
   logic meta_reg;
   logic sync_reg;

   // Metastability settles in the first stage
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
      end
      else
      begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;
endmodule : aopc_sync
`default_nettype wire

// ==== logic/aopc_duty_stab.sv ====
// Purpose: Duty-cycle stabilizer: period tracking, internal falling edge and lock.
// Assumes: rise_seen_i pulses once per encode rise, already in the control domain.
// Notes: Falling edge is placed on a control-clock grid, so duty is exact only for slow clocks.
`timescale 1ns/100ps
`default_nettype none
module aopc_duty_stab (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic rise_seen_i,
   input wire logic rtog_i,
   input wire logic stab_en_i,
   output logic fall_tog_o,
   output logic locked_o
);
   import aopc_pkg::*;

   logic [7:0] gap_reg;
   logic [7:0] half_reg;
   logic [7:0] fall_cnt_reg;
   logic [6:0] lock_cnt_reg;
   logic fall_tog_reg;
   logic locked_reg;
   logic stopped;
   logic [7:0] half_now;

   assign stopped = (gap_reg >= STOP_CNT);
   assign half_now = gap_reg >> 1;

   // Gap since last rise doubles as the period estimate; saturates when stopped
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         gap_reg <= GAP_MAX;
      else if (rise_seen_i)
         gap_reg <= 8'h01;
      else if (gap_reg != GAP_MAX)
         gap_reg <= gap_reg + 8'h01;
   end

   // Half period is latched at each rise whatever the duty of the source
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         half_reg <= 8'h00;
      else if (rise_seen_i)
         half_reg <= half_now;
   end

   // Internal fall lands half a period after the rise, less the sync delay
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         fall_cnt_reg <= 8'h00;
      else if (rise_seen_i && stab_en_i)
         fall_cnt_reg <= (half_now > SYNC_LAT) ? (half_now - SYNC_LAT) : 8'h01;
      else if (fall_cnt_reg != 8'h00)
         fall_cnt_reg <= fall_cnt_reg - 8'h01;
   end

   // External falling edge is never looked at here
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         fall_tog_reg <= 1'b0;
      else if (fall_cnt_reg == 8'h01)
         fall_tog_reg <= rtog_i;
   end

   // Relock after a stop or a fresh enable takes a full run of rises
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         lock_cnt_reg <= 7'h00;
         locked_reg <= 1'b0;
      end
      else if (!stab_en_i || stopped)
      begin
         lock_cnt_reg <= 7'h00;
         locked_reg <= 1'b0;
      end
      else if (rise_seen_i && !locked_reg)
      begin
         if (lock_cnt_reg == 7'(LOCK_EDGES - 1))
            locked_reg <= 1'b1;
         else
            lock_cnt_reg <= lock_cnt_reg + 7'h01;
      end
   end

   assign fall_tog_o = fall_tog_reg;
   assign locked_o = locked_reg;

   property p_half_track;
      @(posedge clk_i) disable iff (!nrst_i)
      rise_seen_i |=> half_reg == ($past(gap_reg) >> 1);
   endproperty
   a_half_track: assert property (p_half_track) else $error("half period not tracked");

   property p_fall_place;
      @(posedge clk_i) disable iff (!nrst_i)
      (fall_cnt_reg == 8'h01) |=> fall_tog_reg == $past(rtog_i);
   endproperty
   a_fall_place: assert property (p_fall_place) else $error("internal fall missed");

   property p_stop_unlock;
      @(posedge clk_i) disable iff (!nrst_i)
      (stopped && stab_en_i) |=> !locked_reg && lock_cnt_reg == 7'h00;
   endproperty
   a_stop_unlock: assert property (p_stop_unlock) else $error("lock held across stop");

   property p_lock_count;
      @(posedge clk_i) disable iff (!nrst_i)
      $rose(locked_reg) |-> $past(lock_cnt_reg) == 7'(LOCK_EDGES - 1);
   endproperty
   a_lock_count: assert property (p_lock_count) else $error("lock before full count");
endmodule : aopc_duty_stab
`default_nettype wire

// ==== logic/aopc_top.sv ====
// Purpose: Output formatting, data-ready clock, tri-state and power-down control.
// Assumes: Core code arrives offset binary on the encode clock; pins are asynchronous.
// Notes: Both domains share the asynchronous reset; encode domain must see it released.
// Operation
// - Stabilizer samples rising edge, makes own fall.
// - Stabilizer accepts 20-80% duty, keeps half.
// - Stabilizer needs hundred cycles relock after stop.
// - Ground or third: offset binary; third stabilizes.
// - Two thirds or supply: two's complement coding.
// - Overflow flag high when input out of range.
// - Data-ready clock follows encode; data after rise.
// - Output enable high tri-states all outputs.
// - Power-down select low means normal operation.
// - Select and enable high: sleep, slow recovery.
// - Select high, enable low: nap, 100-cycle recovery; from sleep or sleep recovery, code goes to sleep.
// - Sleep and nap tri-state every output.
`timescale 1ns/100ps
`default_nettype none
module aopc_top #(
   parameter int SLEEP_WAKE_CYCLES_P = aopc_pkg::SLEEP_WAKE_CYCLES
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic encode_clock_in_i,
   input wire logic [aopc_pkg::SAMPLE_W-1:0] core_code_i,
   input wire logic core_over_i,
   input wire logic core_under_i,
   input wire logic [1:0] mode_level_i,
   input wire logic power_down_select_i,
   input wire logic out_enable_n_i,
   output logic [aopc_pkg::SAMPLE_W-1:0] sample_word_o,
   output logic range_overflow_flag_o,
   output logic data_ready_clock_o,
   output logic sample_valid_o,
   output logic out_oe_n_o,
   output logic reference_on_o,
   output logic core_on_o,
   output logic stab_active_o
);
   import aopc_pkg::*;

   aopc_pwr_t state_reg;
   aopc_pwr_t state_next;
   logic [WAKE_W-1:0] wake_cnt_reg;
   logic [SYNC_C_W-1:0] async_c;
   logic [SYNC_C_W-1:0] sync_c;
   logic [SYNC_E_W-1:0] async_e;
   logic [SYNC_E_W-1:0] sync_e;
   logic oen_c;
   logic pd_c;
   logic [1:0] mode_c;
   logic rtog_c;
   logic rtog_d_reg;
   logic rise_seen;
   logic stab_c;
   logic locked;
   logic fall_tog_stab;
   logic valid_clk_reg;
   logic out_hiz_reg;
   logic ref_on_reg;
   logic core_on_reg;
   logic [1:0] mode_e;
   logic stab_e;
   logic twos_e;
   logic valid_e;
   logic r_tog_reg;
   logic f_tog_neg_reg;
   logic [SAMPLE_W-1:0] sample_word_reg;
   logic overflow_reg;
   logic sample_valid_reg;

   // Pins and the encode toggle enter the control domain
   assign async_c = {r_tog_reg, mode_level_i, power_down_select_i, out_enable_n_i};
   // Mode is a strap and the valid level changes rarely, so level sync suffices
   assign async_e = {mode_level_i, valid_clk_reg};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_C_W; gi++)
      begin : g_sync_c
         aopc_sync u_sync_c (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .async_i(async_c[gi]),
            .sync_o(sync_c[gi])
         );
      end
      for (gi = 0; gi < SYNC_E_W; gi++)
      begin : g_sync_e
         aopc_sync u_sync_e (
            .clk_i(encode_clock_in_i),
            .nrst_i(nrst_i),
            .async_i(async_e[gi]),
            .sync_o(sync_e[gi])
         );
      end
   endgenerate

   assign oen_c = sync_c[0];
   assign pd_c = sync_c[1];
   assign mode_c = sync_c[3:2];
   assign rtog_c = sync_c[4];
   assign valid_e = sync_e[0];
   assign mode_e = sync_e[2:1];

   // Intermediate levels turn the stabilizer on; upper half selects two's complement
   assign stab_c = (mode_c == MODE_THIRD) || (mode_c == MODE_TWO_THIRDS);
   assign stab_e = (mode_e == MODE_THIRD) || (mode_e == MODE_TWO_THIRDS);
   assign twos_e = mode_e[MODE_FMT_BIT];

   // Each toggle change of the synced encode toggle marks one encode rise
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rtog_d_reg <= 1'b0;
      else
         rtog_d_reg <= rtog_c;
   end
   assign rise_seen = rtog_c ^ rtog_d_reg;

   aopc_duty_stab u_stab (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .rise_seen_i(rise_seen),
      .rtog_i(rtog_c),
      .stab_en_i(stab_c),
      .fall_tog_o(fall_tog_stab),
      .locked_o(locked)
   );

   // Power state selection; select low always wins back normal operation
   always_comb
   begin
      state_next = state_reg;
      unique case (state_reg)
         PWR_RUN:
            if (pd_c)
               state_next = oen_c ? PWR_SLEEP : PWR_NAP;
         PWR_NAP:
            if (!pd_c)
               state_next = PWR_NAP_WAKE;
            else if (oen_c)
               state_next = PWR_SLEEP;
         PWR_SLEEP:
            if (!pd_c)
               state_next = PWR_SLEEP_WAKE;
         PWR_NAP_WAKE:
            if (pd_c)
               state_next = oen_c ? PWR_SLEEP : PWR_NAP;
            else if (rise_seen && wake_cnt_reg == WAKE_W'(NAP_WAKE_EDGES - 1))
               state_next = PWR_RUN;
         PWR_SLEEP_WAKE:
            if (pd_c)
               state_next = PWR_SLEEP;
            else if (wake_cnt_reg == WAKE_W'(SLEEP_WAKE_CYCLES_P - 1))
               state_next = PWR_RUN;
      endcase
   end

   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         state_reg <= PWR_RUN;
      else
         state_reg <= state_next;
   end

   // Nap recovery counts encode rises, sleep recovery counts control cycles
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         wake_cnt_reg <= '0;
      else if (state_next != state_reg)
         wake_cnt_reg <= '0;
      else if (state_reg == PWR_SLEEP_WAKE)
         wake_cnt_reg <= wake_cnt_reg + WAKE_W'(1);
      else if (state_reg == PWR_NAP_WAKE && rise_seen)
         wake_cnt_reg <= wake_cnt_reg + WAKE_W'(1);
   end

   // Valid only in normal operation with a locked stabilizer when it is used
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         valid_clk_reg <= 1'b0;
      else
         valid_clk_reg <= (state_reg == PWR_RUN) && (!stab_c || locked);
   end

   // Output tri-state and supply controls; outputs start released
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         out_hiz_reg <= 1'b1;
         ref_on_reg <= 1'b0;
         core_on_reg <= 1'b0;
      end
      else
      begin
         out_hiz_reg <= oen_c || state_reg == PWR_NAP || state_reg == PWR_SLEEP;
         ref_on_reg <= (state_reg != PWR_SLEEP);
         core_on_reg <= (state_reg != PWR_SLEEP) && (state_reg != PWR_NAP);
      end
   end

   // Encode rise toggle: the data-ready clock rises with each rising edge
   always_ff @(posedge encode_clock_in_i or negedge nrst_i)
   begin
      if (!nrst_i)
         r_tog_reg <= 1'b0;
      else
         r_tog_reg <= ~r_tog_reg;
   end

   // External fall used only with stabilizer off; needs a sane source duty
   always_ff @(negedge encode_clock_in_i or negedge nrst_i)
   begin
      if (!nrst_i)
         f_tog_neg_reg <= 1'b0;
      else
         f_tog_neg_reg <= r_tog_reg;
   end

   // Sample outputs change on the rise so they are steady at the ready fall
   always_ff @(posedge encode_clock_in_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sample_word_reg <= '0;
         overflow_reg <= 1'b0;
         sample_valid_reg <= 1'b0;
      end
      else
      begin
         sample_word_reg <= twos_e ? (core_code_i ^ MSB_FLIP) : core_code_i;
         overflow_reg <= core_over_i || core_under_i;
         sample_valid_reg <= valid_e;
      end
   end

   // Only one toggle moves at a time, so the XOR output does not glitch
   assign data_ready_clock_o = r_tog_reg ^ (stab_e ? fall_tog_stab : f_tog_neg_reg);
   assign sample_word_o = sample_word_reg;
   assign range_overflow_flag_o = overflow_reg;
   assign sample_valid_o = sample_valid_reg;
   assign out_oe_n_o = out_hiz_reg;
   assign reference_on_o = ref_on_reg;
   assign core_on_o = core_on_reg;
   assign stab_active_o = stab_c;

   sequence s_run_sleep_req;
      state_reg == PWR_RUN && pd_c && oen_c;
   endsequence

   sequence s_nap_exit;
      state_reg == PWR_NAP && !pd_c && !oen_c;
   endsequence

   property p_sleep_entry;
      @(posedge clk_i) disable iff (!nrst_i)
      s_run_sleep_req |=> state_reg == PWR_SLEEP ##1 !ref_on_reg;
   endproperty
   a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

   property p_nap_exit;
      @(posedge clk_i) disable iff (!nrst_i)
      s_nap_exit |=> state_reg == PWR_NAP_WAKE && wake_cnt_reg == '0 ##1 ref_on_reg;
   endproperty
   a_nap_exit: assert property (p_nap_exit) else $error("nap exit wrong");

   property p_nap_wake_len;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == PWR_NAP_WAKE && wake_cnt_reg < WAKE_W'(NAP_WAKE_EDGES - 1)) |=>
         state_reg != PWR_RUN;
   endproperty
   a_nap_wake_len: assert property (p_nap_wake_len) else $error("nap recovery short");

   property p_pd_hiz;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == PWR_NAP || state_reg == PWR_SLEEP) |=> out_oe_n_o && !core_on_o;
   endproperty
   a_pd_hiz: assert property (p_pd_hiz) else $error("outputs driven in power-down");

   property p_oe_hiz;
      @(posedge clk_i) disable iff (!nrst_i)
      oen_c |=> out_oe_n_o;
   endproperty
   a_oe_hiz: assert property (p_oe_hiz) else $error("outputs driven while disabled");

   property p_run_hold;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == PWR_RUN && !pd_c) |=> state_reg == PWR_RUN ##1 out_oe_n_o == $past(oen_c);
   endproperty
   a_run_hold: assert property (p_run_hold) else $error("normal operation left");

   property p_wake_invalid;
      @(posedge clk_i) disable iff (!nrst_i)
      (state_reg != PWR_RUN || (stab_c && !locked)) |=> !valid_clk_reg;
   endproperty
   a_wake_invalid: assert property (p_wake_invalid) else $error("valid during recovery");

   property p_twos_code;
      @(posedge encode_clock_in_i) disable iff (!nrst_i)
      twos_e |=> sample_word_o == ($past(core_code_i) ^ MSB_FLIP);
   endproperty
   a_twos_code: assert property (p_twos_code) else $error("two's complement coding wrong");

   property p_offset_code;
      @(posedge encode_clock_in_i) disable iff (!nrst_i)
      !twos_e |=> sample_word_o == $past(core_code_i);
   endproperty
   a_offset_code: assert property (p_offset_code) else $error("offset binary coding wrong");

   property p_overflow;
      @(posedge encode_clock_in_i) disable iff (!nrst_i)
      1'b1 |=> range_overflow_flag_o == ($past(core_over_i) || $past(core_under_i));
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow flag wrong");

   property p_ready_rise;
      @(posedge encode_clock_in_i) disable iff (!nrst_i)
      1'b1 |=> r_tog_reg != $past(r_tog_reg);
   endproperty
   a_ready_rise: assert property (p_ready_rise) else $error("ready toggle stuck");
endmodule : aopc_top
`default_nettype wire

// ==== test/aopc_capture_model.sv ====
// Purpose: Downstream capture logic that latches the converter outputs.
// Assumes: One active-low out_oe_n_i tri-states every output pin together.
// Notes: A released pin shows the inverse of its last driven level, so stale data never passes.
`timescale 1ns/100ps
`default_nettype none
module aopc_capture_model (
   input wire logic nrst_i,
   input wire logic data_ready_clock_i,
   input wire logic [aopc_pkg::SAMPLE_W-1:0] sample_word_i,
   input wire logic range_overflow_flag_i,
   input wire logic sample_valid_i,
   input wire logic out_oe_n_i,
   output logic [aopc_pkg::SAMPLE_W-1:0] cap_word_o,
   output logic cap_flag_o,
   output logic cap_valid_o
);
   import aopc_pkg::*;
   logic [13:0] last_q;
   logic [13:0] pin_w;
   // Last level seen while the pins were driven
   always_latch
   begin
      if (!out_oe_n_i)
         last_q <= {data_ready_clock_i, range_overflow_flag_i, sample_valid_i, sample_word_i};
   end
   // Floating pins drift away from their last level
   assign pin_w = out_oe_n_i ? ~last_q :
      {data_ready_clock_i, range_overflow_flag_i, sample_valid_i, sample_word_i};
   // Latch word and flags on the falling edge of the data-ready clock
   always_ff @(negedge pin_w[13] or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cap_word_o <= 11'h000;
         cap_flag_o <= 1'b0;
         cap_valid_o <= 1'b0;
      end
      else
      begin
         cap_word_o <= pin_w[10:0];
         cap_flag_o <= pin_w[12];
         cap_valid_o <= pin_w[11];
      end
   end
endmodule : aopc_capture_model
`default_nettype wire

// ==== test/adc_output_and_power_control_bench.sv ====
// Purpose: Self-checking bench for aopc_top with a capture model downstream.
// Assumes: 8 ns control clock; 32 ns encode clock with its own phase.
// Notes: Sleep recovery shortened to 20 cycles; waits are in control cycles.
`timescale 1ns/100ps
`default_nettype none
module adc_output_and_power_control_bench;
   import aopc_pkg::*;
   localparam int WAKE_P = 20;
   localparam int LIMIT = 20000;
   logic clk_i, nrst_i, enc_i, enc_run, pd_i, oen_i, over_i, under_i;
   logic [1:0] mode_i;
   logic [SAMPLE_W-1:0] code_i, word_o, cap_word;
   logic flag_o, drc_o, valid_o, oe_n_o, ref_o, core_o, stab_o, cap_flag, cap_valid;
   int enc_hi, n_errors, n_tests, cyc;
   logic [10:0] codes [5] = '{11'h000, 11'h3FF, 11'h400, 11'h7FF, 11'h555};
   // Control clock
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // Encode clock; odd offset keeps its edges off clk_i, and it can be stopped
   initial
   begin
      enc_i = 1'b0;
      #5.3;
      forever
      begin
         if (enc_run)
         begin
            enc_i = 1'b1;
            #(enc_hi);
            enc_i = 1'b0;
            #(32 - enc_hi);
         end
         else
            #32;
      end
   end
   aopc_top #(.SLEEP_WAKE_CYCLES_P(WAKE_P)) i_aopc_top (
      .clk_i(clk_i), .nrst_i(nrst_i), .encode_clock_in_i(enc_i), .core_code_i(code_i),
      .core_over_i(over_i), .core_under_i(under_i), .mode_level_i(mode_i),
      .power_down_select_i(pd_i), .out_enable_n_i(oen_i), .sample_word_o(word_o),
      .range_overflow_flag_o(flag_o), .data_ready_clock_o(drc_o), .sample_valid_o(valid_o),
      .out_oe_n_o(oe_n_o), .reference_on_o(ref_o), .core_on_o(core_o), .stab_active_o(stab_o));
   aopc_capture_model i_aopc_capture_model (
      .nrst_i(nrst_i), .data_ready_clock_i(drc_o), .sample_word_i(word_o),
      .range_overflow_flag_i(flag_o), .sample_valid_i(valid_o), .out_oe_n_i(oe_n_o),
      .cap_word_o(cap_word), .cap_flag_o(cap_flag), .cap_valid_o(cap_valid));
   task automatic chk_bit(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [10:0] got, input logic [10:0] exp, input string what);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk_word
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_clk
   // Pins are slow level inputs; n covers their synchronisers
   task automatic set_pins(input logic pd, input logic oen, input int n);
      @(posedge clk_i);
      #1;
      pd_i = pd;
      oen_i = oen;
      wait_clk(n);
   endtask : set_pins
   // Core inputs change just after an encode rise, then two samples pass
   task automatic set_core(input logic [10:0] code, input logic ov, input logic un);
      @(posedge enc_i);
      #1;
      code_i = code;
      over_i = ov;
      under_i = un;
      wait_clk(12);
   endtask : set_core
   task automatic end_test(input string name);
      $display("Test %s finished", name);
   endtask : end_test
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : wrap_up
   // Hang guard, well above the few thousand cycles the tests need
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         n_errors++;
         $display("Error at %0t: timeout", $time);
         wrap_up();
      end
   end
   initial
   begin
      nrst_i = 1'b0;
      enc_run = 1'b1;
      enc_hi = 16;
      {pd_i, oen_i, over_i, under_i} = 4'h0;
      mode_i = MODE_GND;
      code_i = 11'h000;
      n_errors = 0;
      n_tests = 0;
      cyc = 0;
      wait_clk(3);
      chk_bit(oe_n_o, 1'b1, "oe_n in reset");
      nrst_i = 1'b1;
      wait_clk(6);
      chk_bit(oe_n_o, 1'b0, "oe_n after reset");
      chk_bit(core_o, 1'b1, "core on");
      end_test("reset");
      // Every mode level: stabilizer choice and output coding
      for (int m = 0; m < 4; m++)
      begin
         mode_i = 2'(m);
         wait_clk(480);
         chk_bit(stab_o, m == 1 || m == 2, "stabilizer");
         foreach (codes[k])
         begin
            set_core(codes[k], 1'b0, 1'b0);
            chk_word(cap_word, codes[k] ^ (m > 1 ? MSB_FLIP : 11'h000), "word");
            chk_bit(cap_valid, 1'b1, "valid");
         end
      end
      for (int i = 0; i < 4; i++)
      begin
         set_core(11'h2AA, i[0], i[1]);
         chk_bit(cap_flag, i != 0, "overflow");
      end
      @(posedge enc_i);
      #10;
      chk_bit(drc_o, 1'b1, "ready high");
      #14;
      chk_bit(drc_o, 1'b0, "ready low");
      end_test("coding");
      // Short-duty clock, then a long stop that forces a relock
      mode_i = MODE_THIRD;
      enc_hi = 8;
      wait_clk(480);
      @(posedge enc_i);
      #10;
      chk_bit(drc_o, 1'b1, "internal fall");
      set_core(11'h123, 1'b0, 1'b0);
      chk_bit(cap_valid, 1'b1, "locked at quarter duty");
      enc_run = 1'b0;
      wait_clk(300);
      enc_run = 1'b1;
      wait_clk(80);
      chk_bit(cap_valid, 1'b0, "relocking");
      wait_clk(440);
      chk_bit(cap_valid, 1'b1, "relocked");
      enc_hi = 16;
      mode_i = MODE_GND;
      end_test("stabilizer");
      // Tri-state tried in normal operation, select low
      set_pins(1'b0, 1'b1, 6);
      chk_bit(oe_n_o, 1'b1, "oe high");
      chk_bit(core_o, 1'b1, "pd low runs");
      set_pins(1'b0, 1'b0, 6);
      chk_bit(oe_n_o, 1'b0, "oe low");
      end_test("tristate");
      set_pins(1'b1, 1'b0, 6);
      chk_bit(oe_n_o, 1'b1, "nap outputs");
      chk_bit(core_o, 1'b0, "nap core");
      chk_bit(ref_o, 1'b1, "nap reference");
      set_pins(1'b0, 1'b0, 24);
      chk_bit(cap_valid, 1'b0, "nap recovering");
      wait_clk(440);
      chk_bit(cap_valid, 1'b1, "nap recovered");
      end_test("nap");
      set_pins(1'b1, 1'b1, 6);
      chk_bit(oe_n_o, 1'b1, "sleep outputs");
      chk_bit(ref_o, 1'b0, "sleep reference");
      chk_bit(core_o, 1'b0, "sleep core");
      set_pins(1'b0, 1'b0, 14);
      chk_bit(ref_o, 1'b1, "sleep exit reference");
      chk_bit(cap_valid, 1'b0, "sleep recovering");
      wait_clk(WAKE_P * 3);
      chk_bit(cap_valid, 1'b1, "sleep recovered");
      end_test("sleep");
      wrap_up();
   end
endmodule : adc_output_and_power_control_bench
`default_nettype wire
